// *** core/qdac_ctrl.v ***
`timescale 1ns/10ps
`default_nettype none
`include "qdac_regs.vh"
module qdac_ctrl
(
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire din_i,
  input wire load_all_n_i,
  input wire clear_all_n_i,
  input wire shutdown_permit_i,
  output reg dout_o,
  output reg user_logic_output_o,
  output reg shutdown_o,
  output reg phase_rising_o,
  output reg [7:0] conv_a_o,
  output reg [7:0] conv_b_o,
  output reg [7:0] conv_c_o,
  output reg [7:0] conv_d_o
);
  // ==========================================================
  // pin synchronisers
  // ==========================================================
  wire [5:0] sync_w;
  qdac_sync u_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({shutdown_permit_i, clear_all_n_i, load_all_n_i, din_i, ~sclk_i, cs_n_i}),
    .rst_val_i(6'h3F),
    .q_o(sync_w)
  );
  wire cs_n_s = sync_w[0];
  // shift clock travels inverted: the all-ones reset then reads as idle low,
  // so no false edge follows reset
  wire sclk_s = ~sync_w[1];
  wire din_s = sync_w[2];
  wire load_all_n_s = sync_w[3];
  wire clear_all_n_s = sync_w[4];
  wire permit_s = sync_w[5];

  // ==========================================================
  // edge detection
  // ==========================================================
  reg sclk_d_r;
  reg cs_n_d_r;
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end
    else if (ce_i)
    begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire cs_rise = cs_n_s & ~cs_n_d_r;

  // ==========================================================
  // shift register and serial output
  // ==========================================================
  reg [11:0] shift_r;
  reg [11:0] shift_nxt;
  reg dout_nxt;
  // extra leading bits fall out of the top, so 16-bit frames work
  always @*
  begin
    shift_nxt = shift_r;
    dout_nxt = dout_o;
    if (!cs_n_s)
    begin
      if (sclk_rise)
        shift_nxt = {shift_r[`QDAC_WORD_W-2:0], din_s};
      // falling-edge mode presents the next bit to shift out, half a clock ahead of its rise
      if (phase_rising_o && sclk_rise)
        dout_nxt = shift_r[`QDAC_WORD_W-1];
      else if (!phase_rising_o && sclk_fall)
        dout_nxt = shift_r[`QDAC_WORD_W-1];
    end
    // deselected: nothing shifts, dout holds, always driven
  end

  // ==========================================================
  // command decode
  // ==========================================================
  wire [3:0] code_w = shift_r[`QDAC_CODE_HI:`QDAC_CODE_LO];
  wire [1:0] ch_w = shift_r[`QDAC_CH_HI:`QDAC_CH_LO];
  wire [1:0] ctl_w = shift_r[`QDAC_CTL_HI:`QDAC_CTL_LO];
  wire [7:0] byte_w = shift_r[`QDAC_DATA_HI:0];

  reg [7:0] inp_r [0:3];
  reg [7:0] inp_nxt [0:3];
  reg [7:0] conv_nxt [0:3];
  reg [7:0] conv_cur [0:3];
  reg upo_nxt;
  reg shdn_nxt;
  reg phase_nxt;
  reg copy_all;
  integer i;
  integer j;

  always @*
  begin
    conv_cur[0] = conv_a_o;
    conv_cur[1] = conv_b_o;
    conv_cur[2] = conv_c_o;
    conv_cur[3] = conv_d_o;
    copy_all = 1'b0;
    upo_nxt = user_logic_output_o;
    shdn_nxt = shutdown_o;
    phase_nxt = phase_rising_o;
    for (i = 0; i < 4; i = i + 1)
    begin
      inp_nxt[i] = inp_r[i];
      conv_nxt[i] = conv_cur[i];
    end
    if (cs_rise)
    begin
      if (ctl_w == `QDAC_CTL_INPUT)
        inp_nxt[ch_w] = byte_w;
      else if (ctl_w == `QDAC_CTL_BOTH)
      begin
        inp_nxt[ch_w] = byte_w;
        copy_all = 1'b1;
      end
      else
      begin
        case (code_w)
          `QDAC_CMD_LDALL:
          begin
            copy_all = 1'b1;
            shdn_nxt = 1'b0;
          end
          `QDAC_CMD_SETALL:
          begin
            for (i = 0; i < 4; i = i + 1)
              conv_nxt[i] = byte_w;
            shdn_nxt = 1'b0;
          end
          `QDAC_CMD_SHDN:
            if (permit_s)
              shdn_nxt = 1'b1;
          `QDAC_CMD_ULOW:
            upo_nxt = 1'b0;
          `QDAC_CMD_UHIGH:
            upo_nxt = 1'b1;
          `QDAC_CMD_RISE:
          begin
            phase_nxt = 1'b1;
            copy_all = 1'b1;
          end
          `QDAC_CMD_FALL:
          begin
            phase_nxt = 1'b0;
            copy_all = 1'b1;
          end
          default:
            ; // no-operation leaves everything
        endcase
      end
    end
    // level-sensitive load-all keeps converters tracking inputs
    if (!load_all_n_s)
      copy_all = 1'b1;
    if (copy_all)
      for (i = 0; i < 4; i = i + 1)
        conv_nxt[i] = inp_nxt[i];
  end

  // ==========================================================
  // state registers
  // ==========================================================
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift_r <= `QDAC_ZERO_WORD;
      dout_o <= 1'b0;
      phase_rising_o <= 1'b0;
      user_logic_output_o <= 1'b0;
      shutdown_o <= 1'b0;
      for (j = 0; j < 4; j = j + 1)
        inp_r[j] <= `QDAC_ZERO_BYTE;
      conv_a_o <= `QDAC_ZERO_BYTE;
      conv_b_o <= `QDAC_ZERO_BYTE;
      conv_c_o <= `QDAC_ZERO_BYTE;
      conv_d_o <= `QDAC_ZERO_BYTE;
    end
    else if (ce_i)
    begin
      shift_r <= shift_nxt;
      dout_o <= dout_nxt;
      phase_rising_o <= phase_nxt;
      user_logic_output_o <= upo_nxt;
      shutdown_o <= shdn_nxt;
      // clear pin overrides any input or converter write in the same cycle
      if (!clear_all_n_s)
      begin
        for (j = 0; j < 4; j = j + 1)
          inp_r[j] <= `QDAC_ZERO_BYTE;
        conv_a_o <= `QDAC_ZERO_BYTE;
        conv_b_o <= `QDAC_ZERO_BYTE;
        conv_c_o <= `QDAC_ZERO_BYTE;
        conv_d_o <= `QDAC_ZERO_BYTE;
      end
      else
      begin
        for (j = 0; j < 4; j = j + 1)
          inp_r[j] <= inp_nxt[j];
        conv_a_o <= conv_nxt[0];
        conv_b_o <= conv_nxt[1];
        conv_c_o <= conv_nxt[2];
        conv_d_o <= conv_nxt[3];
      end
    end
  end
endmodule // qdac_ctrl
`default_nettype wire

// *** core/qdac_regs.vh ***
// What this block does
// - power-up clears shifter, registers, falling phase
// - twelve-bit word msb first, extra leading ignored
// - sample input on rising clock while selected
// - output delayed twelve bits, edge by mode
// - serial output always driven, never floats
// - deselected: no shifting, output holds level
// - chip-select rise decodes and executes command
// - word: channel, control, data byte
// - control 01 loads selected input register
// - control 11 loads input, updates all converters
// - load-all low copies inputs to converters
// - clear low zeroes inputs and converters
// - shutdown only while permit pin high
// - channel codes 0..3 select A..D
// - 0100 copies all; 1000 loads all; wake
// - 1100 shutdown; 0010 output low; 0110 high
// - 1110 rising phase, 1010 falling; update all
`ifndef QDAC_REGS_VH
`define QDAC_REGS_VH
`define QDAC_WORD_W 12
`define QDAC_DATA_W 8
`define QDAC_CODE_HI 11
`define QDAC_CODE_LO 8
`define QDAC_DATA_HI 7
`define QDAC_CH_HI 11
`define QDAC_CH_LO 10
`define QDAC_CTL_HI 9
`define QDAC_CTL_LO 8
`define QDAC_CMD_NOP 4'h0
`define QDAC_CMD_LDALL 4'h4
`define QDAC_CMD_SETALL 4'h8
`define QDAC_CMD_SHDN 4'hC
`define QDAC_CMD_ULOW 4'h2
`define QDAC_CMD_UHIGH 4'h6
`define QDAC_CMD_RISE 4'hE
`define QDAC_CMD_FALL 4'hA
`define QDAC_CTL_INPUT 2'h1
`define QDAC_CTL_BOTH 2'h3
`define QDAC_ZERO_WORD 12'h000
`define QDAC_ZERO_BYTE 8'h00
`endif

// *** core/qdac_sync.v ***
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for pins from outside clk_i domain
module qdac_sync
(
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [5:0] d_i,
  input wire [5:0] rst_val_i,
  output wire [5:0] q_o
);
  // reset value is all ones for every bit; the rst_val_i tie-off cancels out of q_o
  reg [5:0] s1_r;
  reg [5:0] s2_r;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_bit
      always @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          s1_r[g] <= 1'b1;
          s2_r[g] <= 1'b1;
        end
        else if (ce_i)
        begin
          s1_r[g] <= d_i[g];
          s2_r[g] <= s1_r[g];
        end
      end
    end
  endgenerate
  assign q_o = s2_r ^ ~rst_val_i ^ ~rst_val_i;
endmodule // qdac_sync
`default_nettype wire

// *** verification/qdac_ctrl_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module qdac_ctrl_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic load_all_n_i,
  input wire logic clear_all_n_i,
  input wire logic shutdown_permit_i,
  input wire logic dout_o,
  input wire logic user_logic_output_o,
  input wire logic shutdown_o,
  input wire logic phase_rising_o,
  input wire logic [7:0] conv_a_o,
  input wire logic [7:0] conv_b_o,
  input wire logic [7:0] conv_c_o,
  input wire logic [7:0] conv_d_o
);
  wire [31:0] conv = {conv_a_o, conv_b_o, conv_c_o, conv_d_o};
  wire [2:0] st = {user_logic_output_o, shutdown_o, phase_rising_o};
  // ========================================
  // link and command timing
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst; $fell(rst_i) |-> conv == 0 && !dout_o && st == 0; endproperty
  property p_dout_edge; $changed(dout_o) |-> $past(sclk_i, 2) == phase_rising_o; endproperty
  property p_dout_quiet; $stable(sclk_i) [*6] |-> $stable(dout_o); endproperty
  property p_dout_cs; cs_n_i [*6] |=> $stable(dout_o); endproperty
  property p_st_cause; $changed(st) |-> $past(cs_n_i, 2) && !$past(cs_n_i, 7); endproperty
  // pins idle long enough that no command or pin is still in flight
  property p_conv_hold; (cs_n_i && load_all_n_i && clear_all_n_i) [*8] |=> $stable(conv); endproperty
  property p_clear; !clear_all_n_i [*4] |-> conv == 0; endproperty
  property p_shdn; !shutdown_permit_i [*4] |-> !$rose(shutdown_o); endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared at reset");
  a_dout_edge: assert property (p_dout_edge) else $error("dout on wrong edge");
  a_dout_quiet: assert property (p_dout_quiet) else $error("dout moved, sclk idle");
  a_dout_cs: assert property (p_dout_cs) else $error("dout moved, deselected");
  a_st_cause: assert property (p_st_cause) else $error("state change without cs rise");
  a_conv_hold: assert property (p_conv_hold) else $error("converters moved idle");
  a_clear: assert property (p_clear) else $error("clear did not zero");
  a_shdn: assert property (p_shdn) else $error("shutdown without permit");
  c_shdn: cover property ($rose(shutdown_o));
  c_phase: cover property ($rose(phase_rising_o));
  c_upo: cover property ($fell(user_logic_output_o));
endmodule // qdac_ctrl_properties
bind qdac_ctrl qdac_ctrl_properties qdac_chk_u (.*);
`default_nettype wire

// *** verification/qdac_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module qdac_host (
  input wire logic clk_i,
  input wire logic dout_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  logic [15:0] seen;
  // ========================================
  // serial master
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
    seen = 16'h0000;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // low n bits of the word, msb first; dout sampled just before each rise
  task automatic xfer(input logic [15:0] w, input int n);
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      din_o = w[i];
      wait_clk(4);
      seen = {seen[14:0], dout_i};
      sclk_o = 1'b1;
      wait_clk(4);
      sclk_o = 1'b0;
    end
    wait_clk(8);
    cs_n_o = 1'b1;
    din_o = ~din_o;
    wait_clk(10);
  endtask
  // clock pulses while deselected must shift nothing
  task automatic idle_burst();
    repeat (3)
    begin
      sclk_o = 1'b1;
      wait_clk(4);
      sclk_o = 1'b0;
      wait_clk(4);
    end
  endtask
endmodule // qdac_host
`default_nettype wire

// *** verification/quad_dac_serial_command_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module quad_dac_serial_command_control_tb;
  logic clk_i, rst_i, load_all_n_i, clear_all_n_i, shutdown_permit_i;
  wire cs_n, sclk, din, dout_o, user_logic_output, shdn, phase;
  wire [7:0] ca, cb, cc, cd;
  wire [31:0] conv = {ca, cb, cc, cd};
  int err_count, num_checks;
  qdac_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cs_n_i(cs_n), .sclk_i(sclk),
    .din_i(din), .load_all_n_i(load_all_n_i), .clear_all_n_i(clear_all_n_i),
    .shutdown_permit_i(shutdown_permit_i), .dout_o(dout_o), .user_logic_output_o(user_logic_output),
    .shutdown_o(shdn), .phase_rising_o(phase), .conv_a_o(ca), .conv_b_o(cb), .conv_c_o(cc),
    .conv_d_o(cd));
  qdac_host host_u (.clk_i(clk_i), .dout_i(dout_o), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  // ========================================
  // checks and sequence
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    rst_i = 1'b1;
    load_all_n_i = 1'b1;
    clear_all_n_i = 1'b1;
    shutdown_permit_i = 1'b0;
    err_count = 0;
    num_checks = 0;
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    check({conv, dout_o, phase}, 36'h0);
    for (int k = 0; k < 4; k++)
      host_u.xfer(16'(16'h100 | (k << 10) | (8'h1A + k)), 12);
    check(conv, 36'h0);
    host_u.xfer(16'h400, 12);
    check(conv, 36'h1A1B1C1D);
    check(host_u.seen[11:0], 36'hD1D);
    host_u.xfer(16'h75A, 12);
    check(conv, 36'h1A5A1C1D);
    host_u.xfer(16'h0FF, 12);
    check({user_logic_output, shdn, phase, conv}, 36'h01A5A1C1D);
    host_u.xfer(16'h600, 12);
    check(user_logic_output, 36'h1);
    host_u.xfer(16'h200, 12);
    check(user_logic_output, 36'h0);
    host_u.xfer(16'hC00, 12);
    check(shdn, 36'h0);
    shutdown_permit_i = 1'b1;
    host_u.xfer(16'hC00, 12);
    check(shdn, 36'h1);
    host_u.xfer(16'hF8A5, 16);
    check({shdn, conv}, 36'h0A5A5A5A5);
    host_u.idle_burst();
    check(dout_o, 36'h1);
    host_u.xfer(16'hE00, 12);
    check(host_u.seen[11:0], 36'h8A5);
    check({phase, conv}, 36'h11A5A1C1D);
    host_u.xfer(16'hA00, 12);
    check(host_u.seen[11:0], 36'hF00);
    check(phase, 36'h0);
    host_u.xfer(16'h933, 12);
    check(conv, 36'h1A5A1C1D);
    load_all_n_i = 1'b0;
    host_u.wait_clk(5);
    check(conv, 36'h1A5A331D);
    load_all_n_i = 1'b1;
    clear_all_n_i = 1'b0;
    host_u.wait_clk(5);
    check(conv, 36'h0);
    clear_all_n_i = 1'b1;
    host_u.xfer(16'h400, 12);
    check(conv, 36'h0);
    final_report();
  end
endmodule // quad_dac_serial_command_control_tb
`default_nettype wire
